// [eps_status.sv]
// Exception pending status register with AXI4-Lite access
`timescale 1ns/1ps
`include "eps_defs.svh"

// Summary of operation
// R1 - Writing one to tick clear removes system tick pending; zero does nothing.
// R2 - Tick clear bit is write-only; its read value is undefined (reads zero).
// R3 - Bit 23 reads one when release from halt will take an interrupt.
// R4 - Bit 23 reads zero whenever the core is not halted in debug.
// R5 - Bit 22 reads one when any interrupt is pending.
// R6 - Bit 22 ignores the non-maskable interrupt and fault exceptions.
// R7 - Bits 17:12 give the highest-priority pending enabled exception number.
// R8 - Vector uses base priority threshold and fault mask, not the primary mask.
// R9 - Codes: none 0x00, NMI 0x02, SVC 0x0B, service request 0x0E, tick 0x0F.
// R10 - Codes: hard 0x03, memory 0x04, bus 0x05, usage 0x06.
// R11 - External line n reports code 0x10 plus n.
// R12 - Reserved codes 0x01, 0x07-0x0A, 0x0C, 0x0D are never reported.
// R13 - Writing one to bit 26 sets tick pending; reading it returns the state.
// R14 - Status fields track live state; writes to them are ignored.
module eps_status
   import eps_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic nmi_pending,
   input wire logic [3:0] fault_pending,
   input wire logic svc_pending,
   input wire logic psv_pending,
   input wire logic tick_event,
   input wire logic [42:0] irq_pending,
   input wire logic [42:0] irq_enable,
   input wire logic [128:0] irq_priority,
   input wire logic [11:0] sys_priority,
   input wire logic debug_halted,
   input wire logic tick_taken,
   output logic tick_pending,
   output logic [5:0] pending_vector_number,
   output logic any_irq_pending
);

   localparam int NIRQ = `EPS_NUM_IRQ;
   eps_bus_t wr_state_reg;
   eps_bus_t rd_state_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [3:0] base_priority_threshold_reg;
   logic fault_mask_a_reg;
   logic dbg_irq_reg;
   logic tick_pending_reg;
   eps_vec_t vec_next;
   logic irq_any_next;
   logic dbg_irq_next;
   logic wr_fire;
   logic tick_set_wr;
   logic tick_clr_wr;

   // Threshold of zero disables masking; smaller value means higher priority
   function automatic logic pri_allowed(input logic [2:0] pri, input logic [3:0] thr);
      pri_allowed = (thr == 4'h0) || ({1'b0, pri} < thr);
   endfunction

   // Priority search; lowest number wins ties, NMI and hard fault are fixed top
   always_comb
   begin
      eps_vec_t best;
      logic [3:0] best_pri;
      logic found;
      best = `EPS_VEC_NONE;
      best_pri = 4'hF;
      found = 1'b0;
      irq_any_next = 1'b0;
      if (nmi_pending)
      begin
         best = `EPS_VEC_NMI; // R9
         found = 1'b1;
      end
      else if (fault_pending[0] && !fault_mask_a_reg)
      begin
         best = `EPS_VEC_HARD; // R10
         found = 1'b1;
      end
      for (int i = 1; i < 4; i++)
      begin
         if (!found && fault_pending[i] && !fault_mask_a_reg
             && pri_allowed(sys_priority[3*(i-1) +: 3], base_priority_threshold_reg)
             && {1'b0, sys_priority[3*(i-1) +: 3]} < best_pri) // R8
         begin
            best = 6'(`EPS_VEC_HARD + i); // R10
            best_pri = {1'b0, sys_priority[3*(i-1) +: 3]};
         end
      end
      if (!found && svc_pending && pri_allowed(sys_priority[11:9], base_priority_threshold_reg)
          && {1'b0, sys_priority[11:9]} < best_pri)
      begin
         best = `EPS_VEC_SVC; // R9
         best_pri = {1'b0, sys_priority[11:9]};
      end
      if (!found && psv_pending && pri_allowed(irq_priority[128:126], base_priority_threshold_reg)
          && {1'b0, irq_priority[128:126]} < best_pri)
      begin
         best = `EPS_VEC_PSV; // R9
         best_pri = {1'b0, irq_priority[128:126]};
      end
      if (!found && tick_pending_reg && pri_allowed(sys_priority[2:0], base_priority_threshold_reg)
          && {1'b0, sys_priority[2:0]} < best_pri)
      begin
         best = `EPS_VEC_TICK; // R9
         best_pri = {1'b0, sys_priority[2:0]};
      end
      for (int n = 0; n < NIRQ; n++)
      begin
         if (irq_pending[n])
            irq_any_next = 1'b1; // R6
         if (!found && irq_pending[n] && irq_enable[n]
             && pri_allowed(irq_priority[3*n +: 3], base_priority_threshold_reg)
             && {1'b0, irq_priority[3*n +: 3]} < best_pri)
         begin
            best = 6'(`EPS_VEC_IRQ0 + n); // R11
            best_pri = {1'b0, irq_priority[3*n +: 3]};
         end
      end
      irq_any_next = irq_any_next | psv_pending | tick_pending_reg | svc_pending; // R5
      vec_next = best; // R7 R12
   end

   assign dbg_irq_next = debug_halted && (vec_next != `EPS_VEC_NONE); // R3 R4

   // Write channel: address and data accepted in either order
   assign wr_fire = aw_got_reg && w_got_reg && (wr_state_reg == EPS_IDLE);
   assign tick_set_wr = wr_fire && (aw_addr_reg == `EPS_ICSR_OFFSET) && w_strb_reg[3]
                        && w_data_reg[`EPS_BIT_TICK_SET];
   assign tick_clr_wr = wr_fire && (aw_addr_reg == `EPS_ICSR_OFFSET) && w_strb_reg[3]
                        && w_data_reg[`EPS_BIT_TICK_CLR];

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= `EPS_ZERO32;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EPS_RESP_OKAY;
         wr_state_reg <= EPS_IDLE;
      end
      else
      begin
         s_axi_awready <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready) && wr_state_reg == EPS_IDLE;
         s_axi_wready <= !w_got_reg && !(s_axi_wvalid && s_axi_wready) && wr_state_reg == EPS_IDLE;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[11:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         case (wr_state_reg)
            EPS_IDLE:
            begin
               if (wr_fire)
               begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= (aw_addr_reg == `EPS_ICSR_OFFSET || aw_addr_reg == `EPS_CTRL_OFFSET)
                                 ? `EPS_RESP_OKAY : `EPS_RESP_SLVERR;
                  wr_state_reg <= EPS_RESP;
               end
            end
            EPS_RESP:
            begin
               if (s_axi_bready)
               begin
                  s_axi_bvalid <= 1'b0;
                  aw_got_reg <= 1'b0;
                  w_got_reg <= 1'b0;
                  wr_state_reg <= EPS_IDLE;
               end
            end
            default:
               wr_state_reg <= EPS_IDLE;
         endcase
      end
   end

   // Control register: threshold in bits 3:0, fault mask in bit 8
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         base_priority_threshold_reg <= 4'h0;
         fault_mask_a_reg <= 1'b0;
      end
      else if (wr_fire && aw_addr_reg == `EPS_CTRL_OFFSET)
      begin
         if (w_strb_reg[0])
            base_priority_threshold_reg <= w_data_reg[3:0];
         if (w_strb_reg[1])
            fault_mask_a_reg <= w_data_reg[8];
      end
   end

   // Tick pending: hardware event beats a same-cycle software clear
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         tick_pending_reg <= 1'b0;
      else if (tick_event || tick_set_wr) // R13
         tick_pending_reg <= 1'b1;
      else if (tick_clr_wr || tick_taken) // R1
         tick_pending_reg <= 1'b0;
   end

   // Status snapshot updated every cycle; writes never touch it
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pending_vector_number <= `EPS_VEC_NONE;
         any_irq_pending <= 1'b0;
         dbg_irq_reg <= 1'b0;
         tick_pending <= 1'b0;
      end
      else
      begin
         pending_vector_number <= vec_next; // R14
         any_irq_pending <= irq_any_next; // R14
         dbg_irq_reg <= dbg_irq_next; // R14
         tick_pending <= tick_pending_reg;
      end
   end

   // Read channel, one cycle after address acceptance
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `EPS_ZERO32;
         s_axi_rresp <= `EPS_RESP_OKAY;
         rd_state_reg <= EPS_IDLE;
      end
      else
      begin
         case (rd_state_reg)
            EPS_IDLE:
            begin
               s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
               if (s_axi_arvalid && s_axi_arready)
               begin
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp <= `EPS_RESP_OKAY;
                  s_axi_rdata <= `EPS_ZERO32;
                  rd_state_reg <= EPS_RESP;
                  if ({s_axi_araddr[11:2], 2'h0} == `EPS_ICSR_OFFSET)
                  begin
                     // Clear bit 25 reads zero
                     s_axi_rdata[`EPS_BIT_TICK_SET] <= tick_pending_reg; // R13 R2
                     s_axi_rdata[`EPS_BIT_DBG_IRQ] <= dbg_irq_reg; // R3
                     s_axi_rdata[`EPS_BIT_ANY_IRQ] <= any_irq_pending; // R5
                     s_axi_rdata[`EPS_VEC_MSB:`EPS_VEC_LSB] <= pending_vector_number; // R7
                  end
                  else if ({s_axi_araddr[11:2], 2'h0} == `EPS_CTRL_OFFSET)
                  begin
                     s_axi_rdata[3:0] <= base_priority_threshold_reg;
                     s_axi_rdata[8] <= fault_mask_a_reg;
                  end
                  else
                     s_axi_rresp <= `EPS_RESP_SLVERR;
               end
            end
            EPS_RESP:
            begin
               s_axi_arready <= 1'b0;
               if (s_axi_rready)
               begin
                  s_axi_rvalid <= 1'b0;
                  rd_state_reg <= EPS_IDLE;
               end
            end
            default:
               rd_state_reg <= EPS_IDLE;
         endcase
      end
   end

   sequence s_tick_clear;
      tick_clr_wr && !tick_event && !tick_set_wr;
   endsequence

   AST_TICK_CLEAR: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
      s_tick_clear |=> !tick_pending_reg ##1 !tick_pending) else $error("tick clear lost");
   AST_TICK_SET: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
      tick_set_wr |=> tick_pending_reg) else $error("tick set lost");
   AST_DBG_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
      !$past(debug_halted) |-> !dbg_irq_reg) else $error("debug bit set outside halt");
   AST_DBG_SET: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
      debug_halted && vec_next != `EPS_VEC_NONE |=> dbg_irq_reg) else $error("debug bit missing");
   AST_NMI_CODE: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
      nmi_pending |=> pending_vector_number == `EPS_VEC_NMI) else $error("nmi code wrong");
   AST_ANY_IGNORES_NMI: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
      irq_pending == '0 && !psv_pending && !svc_pending && !tick_pending_reg |=> !any_irq_pending)
      else $error("pending flag counts nmi or fault");
   AST_RESERVED: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
      !(pending_vector_number inside {6'h01, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0C, 6'h0D}))
      else $error("reserved code reported");
   AST_IRQ0: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
      !nmi_pending && fault_pending == 4'h0 && !svc_pending && !psv_pending && !tick_pending_reg
      && base_priority_threshold_reg == 4'h0 && irq_pending == 43'h1 && irq_enable[0]
      |=> pending_vector_number == `EPS_VEC_IRQ0) else $error("irq0 code wrong");
   AST_FMASK: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
      fault_mask_a_reg && !nmi_pending |=> !(pending_vector_number inside {6'h03, 6'h04, 6'h05, 6'h06}))
      else $error("fault shown under mask");
endmodule

// [eps_defs.svh]
// Offsets, field positions, codes and reset values of the exception status block
`ifndef EPS_DEFS_SVH
`define EPS_DEFS_SVH
`define EPS_ICSR_OFFSET 12'hD04
`define EPS_CTRL_OFFSET 12'hD40
`define EPS_BIT_TICK_SET 26
`define EPS_BIT_TICK_CLR 25
`define EPS_BIT_DBG_IRQ 23
`define EPS_BIT_ANY_IRQ 22
`define EPS_VEC_MSB 17
`define EPS_VEC_LSB 12
`define EPS_VEC_NONE 6'h00
`define EPS_VEC_NMI 6'h02
`define EPS_VEC_HARD 6'h03
`define EPS_VEC_MEM 6'h04
`define EPS_VEC_BUS 6'h05
`define EPS_VEC_USAGE 6'h06
`define EPS_VEC_SVC 6'h0B
`define EPS_VEC_PSV 6'h0E
`define EPS_VEC_TICK 6'h0F
`define EPS_VEC_IRQ0 6'h10
`define EPS_NUM_IRQ 43
`define EPS_PRI_W 3
`define EPS_RESP_OKAY 2'h0
`define EPS_RESP_SLVERR 2'h2
`define EPS_ZERO32 32'h00000000
`endif

// [eps_pkg.sv]
// Types of the exception status block
package eps_pkg;
   typedef logic [5:0] eps_vec_t;
   typedef logic [2:0] eps_pri_t;
   typedef enum logic [1:0] {EPS_IDLE = 2'h0, EPS_RESP = 2'h1} eps_bus_t;
endpackage

// [eps_core_model.sv]
// Core model that takes the tick handler after a set delay
`timescale 1ns/1ps
module eps_core_model
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic take_en,
   input wire logic [3:0] delay,
   input wire logic tick_pending,
   output logic tick_taken
);
   logic [3:0] cnt_reg;
   // Restart after each entry, since pending lags by a cycle
   always_ff @(posedge sys_clk)
   begin
      tick_taken <= 1'b0;
      if (sys_rst || !take_en || !tick_pending || tick_taken)
         cnt_reg <= 4'h0;
      else if (cnt_reg == delay)
      begin
         tick_taken <= 1'b1;
         cnt_reg <= 4'h0;
      end
      else
         cnt_reg <= cnt_reg + 4'h1;
   end
endmodule

// [exception_pending_status_tb.sv]
// Self-checking bench of the exception status register
`timescale 1ns/1ps
`include "eps_defs.svh"
module exception_pending_status_tb;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] awa = 12'h000, ara = 12'h000;
   logic awv = 1'b0, wv = 1'b0, bri = 1'b0, arv = 1'b0, rri = 1'b0;
   logic [31:0] wd = 32'h00000000, r_dat;
   logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, tk, tp, anyp;
   logic [1:0] b_rsp, r_rsp;
   logic nmi = 1'b0, svc = 1'b0, psv = 1'b0, tev = 1'b0, dbg = 1'b0, take = 1'b0;
   logic [3:0] flt = 4'h0;
   logic [11:0] spr = 12'h000;
   logic [42:0] ip = 43'h0, ie = 43'h0;
   logic [128:0] ipr = 129'h0;
   logic [5:0] pvn;
   logic [31:0] d;
   logic [1:0] r, br;
   logic [5:0] ev [10] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0B, 6'h0E, 6'h10, 6'h3A, 6'h00};
   int num_errors = 0, samples_checked = 0, cyc = 0;

   eps_status dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(aw_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(w_rdy), .s_axi_bresp(b_rsp), .s_axi_bvalid(b_vld), .s_axi_bready(bri),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_rdata(r_dat),
      .s_axi_rresp(r_rsp), .s_axi_rvalid(r_vld), .s_axi_rready(rri), .nmi_pending(nmi),
      .fault_pending(flt), .svc_pending(svc), .psv_pending(psv), .tick_event(tev),
      .irq_pending(ip), .irq_enable(ie), .irq_priority(ipr), .sys_priority(spr),
      .debug_halted(dbg), .tick_taken(tk), .tick_pending(tp), .pending_vector_number(pvn),
      .any_irq_pending(anyp));
   eps_core_model core (.sys_clk(sys_clk), .sys_rst(sys_rst), .take_en(take), .delay(4'h2),
      .tick_pending(tp), .tick_taken(tk));

   always #2 sys_clk = ~sys_clk;

   task summarize;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles used
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         summarize();
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task wr(input logic [11:0] a, input logic [31:0] v);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bri <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (aw_rdy) awv <= 1'b0;
         if (w_rdy) wv <= 1'b0;
      end
      while (!b_vld);
      br = b_rsp;
      bri <= 1'b0;
   endtask

   task rd(input logic [11:0] a);
      ara <= a;
      arv <= 1'b1;
      rri <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (ar_rdy) arv <= 1'b0;
      end
      while (!r_vld);
      d = r_dat;
      r = r_rsp;
      rri <= 1'b0;
   endtask

   // Bit 25 is masked off: its read value is not defined
   task ck(input logic t, input logic g, input logic y, input logic [5:0] v);
      repeat (3) @(posedge sys_clk);
      rd(`EPS_ICSR_OFFSET);
      chk("icsr", {5'h00, t, 2'h0, g, y, 4'h0, v, 12'h000}, d & 32'hFDFFFFFF);
      chk("rresp", {30'h0, `EPS_RESP_OKAY}, {30'h0, r});
      chk("vec", {26'h0, v}, {26'h0, pvn});
      chk("any", {31'h0, y}, {31'h0, anyp});
      chk("tick", {31'h0, t}, {31'h0, tp});
   endtask

   task clr;
      nmi <= 1'b0;
      svc <= 1'b0;
      psv <= 1'b0;
      flt <= 4'h0;
      ip <= 43'h0;
      ipr <= 129'h0;
   endtask

   initial
   begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      ck(0, 0, 0, 6'h00);
      $display("test reset done");
      for (int k = 0; k < 10; k++)
      begin
         clr();
         ie <= (k == 9) ? 43'h0 : {43{1'b1}};
         case (k)
            0: nmi <= 1'b1;
            1, 2, 3, 4: flt <= 4'h1 << (k - 1);
            5: svc <= 1'b1;
            6: psv <= 1'b1;
            7: ip[0] <= 1'b1;
            default: ip[(k == 8) ? 42 : 7] <= 1'b1;
         endcase
         ck(0, 0, k > 4, ev[k]);
      end
      $display("test codes done");
      clr();
      ie <= {43{1'b1}};
      ip[3] <= 1'b1;
      ip[5] <= 1'b1;
      ipr[11:9] <= 3'h3;
      ipr[17:15] <= 3'h1;
      ck(0, 0, 1, 6'h15);
      ip[5] <= 1'b0;
      for (int t = 2; t < 5; t++)
      begin
         wr(`EPS_CTRL_OFFSET, t);
         ck(0, 0, 1, (t < 4) ? 6'h00 : 6'h13);
      end
      clr();
      flt <= 4'hF;
      wr(`EPS_CTRL_OFFSET, 32'h00000100);
      ck(0, 0, 0, 6'h00);
      nmi <= 1'b1;
      ck(0, 0, 0, 6'h02);
      wr(`EPS_CTRL_OFFSET, 32'h00000000);
      clr();
      svc <= 1'b1;
      spr <= 12'hA00;
      for (int t = 4; t < 7; t += 2)
      begin
         wr(`EPS_CTRL_OFFSET, t);
         ck(0, 0, 1, (t < 6) ? 6'h00 : 6'h0B);
      end
      spr <= 12'h000;
      wr(`EPS_CTRL_OFFSET, 32'h00000000);
      $display("test masks done");
      clr();
      ip[2] <= 1'b1;
      ck(0, 0, 1, 6'h12);
      dbg <= 1'b1;
      ck(0, 1, 1, 6'h12);
      ip[2] <= 1'b0;
      ck(0, 0, 0, 6'h00);
      dbg <= 1'b0;
      $display("test debug done");
      wr(`EPS_ICSR_OFFSET, 32'h04000000);
      chk("bresp", {30'h0, `EPS_RESP_OKAY}, {30'h0, br});
      ck(1, 0, 1, 6'h0F);
      wr(`EPS_ICSR_OFFSET, 32'h00000000);
      ck(1, 0, 1, 6'h0F);
      wr(`EPS_ICSR_OFFSET, 32'h00C3F000);
      ck(1, 0, 1, 6'h0F);
      wr(`EPS_ICSR_OFFSET, 32'h02000000);
      ck(0, 0, 0, 6'h00);
      tev <= 1'b1;
      @(posedge sys_clk);
      tev <= 1'b0;
      ck(1, 0, 1, 6'h0F);
      take <= 1'b1;
      repeat (6) @(posedge sys_clk);
      ck(0, 0, 0, 6'h00);
      take <= 1'b0;
      rd(12'h800);
      chk("resp", {30'h0, `EPS_RESP_SLVERR}, {30'h0, r});
      chk("rdata", 32'h00000000, d);
      wr(12'h800, 32'h04000000);
      chk("bresp", {30'h0, `EPS_RESP_SLVERR}, {30'h0, br});
      ck(0, 0, 0, 6'h00);
      $display("test tick done");
      summarize();
   end
endmodule
